// File: hw/dwm_pkg.sv
// Package of constants and types for the DSP watchdog and execution monitor.
`default_nettype none

package dwm_pkg;

    // Wishbone geometry: register index sits at byte address bits [17:2].
    localparam int unsigned ADR_W  = 18;
    localparam int unsigned DAT_W  = 32;
    localparam int unsigned REG_W  = 16;
    localparam int unsigned IDX_LSB = 2;

    // Register indices; the byte address is four times the index.
    localparam logic [15:0] IDX_ERR_PC     = 16'hF432;
    localparam logic [15:0] IDX_SW_CODE_A  = 16'hF433;
    localparam logic [15:0] IDX_SW_CODE_B  = 16'hF434;
    localparam logic [15:0] IDX_WDG_RELOAD = 16'hF443;
    localparam logic [15:0] IDX_WDG_TICK   = 16'hF444;
    localparam logic [15:0] IDX_FRM_EN     = 16'hF450;
    localparam logic [15:0] IDX_FRM_LEN    = 16'hF451;
    localparam logic [15:0] IDX_PC_UPPER   = 16'hF460;
    localparam logic [15:0] IDX_PC_LOWER   = 16'hF461;
    localparam logic [15:0] IDX_FAULT_CODE = 16'hF470;
    localparam logic [15:0] IDX_IRQ_STAT   = 16'hF471;
    localparam logic [15:0] IDX_IRQ_MASK   = 16'hF472;

    // Reset value shared by every register.
    localparam logic [15:0] REG_RESET = 16'h0000;

    // Field layouts.
    localparam int unsigned RELOAD_W     = 13;
    localparam int unsigned TICK_SEL_W   = 4;
    localparam int unsigned PC_W         = 24;
    localparam int unsigned PC_UPPER_LSB = 16;
    localparam int unsigned PC_UPPER_W   = 8;
    localparam int unsigned FRM_EN_BIT   = 0;
    localparam int unsigned FAULT_WDG_BIT = 12;

    // Interrupt status and mask bits.
    localparam int unsigned IRQ_W       = 3;
    localparam int unsigned IRQ_BLK_BIT = 0;
    localparam int unsigned IRQ_WDG_BIT = 1;
    localparam int unsigned IRQ_ERR_BIT = 2;

    // Prescaler: code 0 gives one tick per 2**6 = 64 clocks.
    localparam int unsigned TICK_BASE_LOG2_DEF = 6;
    localparam logic [3:0]  TICK_SEL_MAX       = 4'hB;

    // Software error trap write port.
    typedef struct packed {
        logic        store;
        logic        sel_b;
        logic [15:0] code;
    } dwm_trap_t;

endpackage

`default_nettype wire

// File: hw/dwm_tick_div.sv
// Prescaler that turns the system clock into watchdog counting ticks.
`default_nettype none

module dwm_tick_div #(
    parameter int unsigned BASE_LOG2 = 6
) (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       nrst,
    // Control.
    input  wire logic       restart,
    input  wire logic [3:0] sel,
    // Tick output.
    output logic            tick
);

    localparam int unsigned CNT_W = BASE_LOG2 + 12;
    localparam logic [CNT_W-1:0] ONE  = CNT_W'(1);
    localparam logic [CNT_W-1:0] ZERO = CNT_W'(0);

    logic [3:0]       code;
    logic [CNT_W-1:0] limit;
    logic [CNT_W-1:0] cnt_q;

    // Reserved codes hold the longest defined period.
    always_comb begin
        code  = (sel > dwm_pkg::TICK_SEL_MAX) ? dwm_pkg::TICK_SEL_MAX : sel;
        limit = (ONE << (BASE_LOG2 + 32'(code))) - ONE;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= ZERO;
        end else if (restart || cnt_q >= limit) begin
            cnt_q <= ZERO;
        end else begin
            cnt_q <= cnt_q + ONE;
        end
    end

    // A restart also realigns the phase so a fresh timeout is a full one.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tick <= 1'b0;
        end else begin
            tick <= !restart && (cnt_q >= limit);
        end
    end

endmodule

`default_nettype wire

// File: hw/dwm_watchdog_exec_monitor.sv
// Watchdog, error capture and frame-group interrupt for the DSP core.
//
// Implementation choice: the Wishbone slave port.
`default_nettype none
// Behaviour
// - Error latches execute-stage program count, readable/writable.
// - Two 16-bit error-code registers, trap may fill.
// - Watchdog starts at reload, decrements per tick.
// - Program restart reloads watchdog counter.
// - Counter reaching zero raises watchdog error flag.
// - Reload is 13 bits; upper three reserved, reset zero.
// - Prescale multiplies the reload count timeout.
// - Tick every 64 clocks, doubling per code to 131072.
// - Bit zero enables frame-group interrupt; resets zero.
// - Frame counter increments on each frame-start pulse.
// - Counter reaching length fires interrupt, then clears.
// - Program counter bits 23:16 readable in low byte.
// - Program counter bits 15:0 readable in companion.
// - Watchdog expiry reported at fault-code bit 12.

module dwm_watchdog_exec_monitor #(
    parameter int unsigned TICK_BASE_LOG2 = dwm_pkg::TICK_BASE_LOG2_DEF
) (
    // Clock and reset.
    input  wire logic                       REF_CLK,
    input  wire logic                       NRST,
    // Wishbone slave.
    input  wire logic                       WB_CYC_I,
    input  wire logic                       WB_STB_I,
    input  wire logic                       WB_WE_I,
    input  wire logic [dwm_pkg::ADR_W-1:0]  WB_ADR_I,
    input  wire logic [3:0]                 WB_SEL_I,
    input  wire logic [dwm_pkg::DAT_W-1:0]  WB_DAT_I,
    output logic      [dwm_pkg::DAT_W-1:0]  WB_DAT_O,
    output logic                            WB_ACK_O,
    // Core observation.
    input  wire logic [dwm_pkg::PC_W-1:0]   CORE_PC,
    input  wire logic [15:0]                EXEC_PC,
    input  wire logic                       CORE_ERROR,
    input  wire logic                       PROG_RESTART,
    input  wire logic                       FRAME_START,
    input  wire dwm_pkg::dwm_trap_t         SW_TRAP,
    // Event outputs.
    output logic                            WDG_ERROR,
    output logic                            BLOCK_IRQ,
    output logic                            IRQ
);

    localparam logic [dwm_pkg::RELOAD_W-1:0] RLD_ONE  = 13'h0001;
    localparam logic [dwm_pkg::RELOAD_W-1:0] RLD_ZERO = 13'h0000;
    localparam logic [15:0] FRM_ONE  = 16'h0001;
    localparam logic [15:0] FRM_ZERO = 16'h0000;
    localparam logic [dwm_pkg::IRQ_W-1:0] IRQ_ZERO = 3'h0;

    // Bus decode.
    logic        req;
    logic        wr;
    logic [15:0] idx;
    logic [15:0] wdat;
    logic [15:0] lane_mask;
    logic        ack_q;

    // Register state.
    logic [15:0] err_pc_q;
    logic [15:0] sw_code_a_q;
    logic [15:0] sw_code_b_q;
    logic [dwm_pkg::RELOAD_W-1:0]   reload_q;
    logic [dwm_pkg::TICK_SEL_W-1:0] tick_sel_q;
    logic        frm_en_q;
    logic [15:0] frm_len_q;
    logic [15:0] fault_q;
    logic [dwm_pkg::IRQ_W-1:0] irq_stat_q;
    logic [dwm_pkg::IRQ_W-1:0] irq_mask_q;

    // Watchdog and frame counter.
    logic [dwm_pkg::RELOAD_W-1:0] wdg_cnt_q;
    logic        wdg_armed_q;
    logic        wdg_tick;
    logic        wdg_load;
    logic [dwm_pkg::RELOAD_W-1:0] wdg_load_val;
    logic        wdg_expire;
    logic [15:0] frm_cnt_q;
    logic        frm_fire;
    logic        err_capture;
    logic [dwm_pkg::IRQ_W-1:0] irq_events;
    logic [15:0] rdata_d;

    function automatic logic wr_hit(input logic [15:0] a,
                                    input logic [15:0] b,
                                    input logic        w);
        return w && (a == b);
    endfunction

    // Wishbone request is taken in the cycle before ack rises.
    always_comb begin
        req       = WB_CYC_I && WB_STB_I && !ack_q;
        wr        = req && WB_WE_I;
        idx       = WB_ADR_I[dwm_pkg::ADR_W-1:dwm_pkg::IDX_LSB];
        wdat      = WB_DAT_I[15:0];
        lane_mask = {{8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    assign WB_ACK_O = ack_q;

    // Watchdog reloads on a program restart or a new reload value.
    always_comb begin
        wdg_load     = PROG_RESTART
                       || wr_hit(idx, dwm_pkg::IDX_WDG_RELOAD, wr);
        wdg_load_val = PROG_RESTART ? reload_q
                     : (wdat[dwm_pkg::RELOAD_W-1:0]
                        & lane_mask[dwm_pkg::RELOAD_W-1:0])
                     | (reload_q & ~lane_mask[dwm_pkg::RELOAD_W-1:0]);
        wdg_expire   = wdg_armed_q && wdg_tick && !wdg_load
                       && (wdg_cnt_q == RLD_ONE);
        err_capture  = CORE_ERROR || wdg_expire;
    end

    dwm_tick_div #(
        .BASE_LOG2 (TICK_BASE_LOG2)
    ) u_tick_div (
        .clk     (REF_CLK),
        .nrst    (NRST),
        .restart (wdg_load),
        .sel     (tick_sel_q),
        .tick    (wdg_tick)
    );

    // A zero reload leaves the watchdog disarmed, so reset never trips it.
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            wdg_cnt_q   <= RLD_ZERO;
            wdg_armed_q <= 1'b0;
        end else if (wdg_load) begin
            wdg_cnt_q   <= wdg_load_val;
            wdg_armed_q <= (wdg_load_val != RLD_ZERO);
        end else if (wdg_armed_q && wdg_tick && wdg_cnt_q != RLD_ZERO) begin
            wdg_cnt_q   <= wdg_cnt_q - RLD_ONE;
        end
    end

    // Hardware capture wins over a software write in the same cycle.
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            err_pc_q <= dwm_pkg::REG_RESET;
        end else if (err_capture) begin
            err_pc_q <= EXEC_PC;
        end else if (wr_hit(idx, dwm_pkg::IDX_ERR_PC, wr)) begin
            err_pc_q <= (wdat & lane_mask) | (err_pc_q & ~lane_mask);
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            sw_code_a_q <= dwm_pkg::REG_RESET;
        end else if (SW_TRAP.store && !SW_TRAP.sel_b) begin
            sw_code_a_q <= SW_TRAP.code;
        end else if (wr_hit(idx, dwm_pkg::IDX_SW_CODE_A, wr)) begin
            sw_code_a_q <= (wdat & lane_mask) | (sw_code_a_q & ~lane_mask);
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            sw_code_b_q <= dwm_pkg::REG_RESET;
        end else if (SW_TRAP.store && SW_TRAP.sel_b) begin
            sw_code_b_q <= SW_TRAP.code;
        end else if (wr_hit(idx, dwm_pkg::IDX_SW_CODE_B, wr)) begin
            sw_code_b_q <= (wdat & lane_mask) | (sw_code_b_q & ~lane_mask);
        end
    end

    // Watchdog configuration; reserved bits are not stored.
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            reload_q   <= dwm_pkg::REG_RESET[dwm_pkg::RELOAD_W-1:0];
            tick_sel_q <= dwm_pkg::REG_RESET[dwm_pkg::TICK_SEL_W-1:0];
        end else begin
            if (wr_hit(idx, dwm_pkg::IDX_WDG_RELOAD, wr)) begin
                // A restart in the same cycle must not swallow the write.
                reload_q <= (wdat[dwm_pkg::RELOAD_W-1:0]
                             & lane_mask[dwm_pkg::RELOAD_W-1:0])
                            | (reload_q
                               & ~lane_mask[dwm_pkg::RELOAD_W-1:0]);
            end
            if (wr_hit(idx, dwm_pkg::IDX_WDG_TICK, wr) && WB_SEL_I[0]) begin
                tick_sel_q <= wdat[dwm_pkg::TICK_SEL_W-1:0];
            end
        end
    end

    // Frame-group configuration.
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            frm_en_q  <= dwm_pkg::REG_RESET[dwm_pkg::FRM_EN_BIT];
            frm_len_q <= dwm_pkg::REG_RESET;
        end else begin
            if (wr_hit(idx, dwm_pkg::IDX_FRM_EN, wr) && WB_SEL_I[0]) begin
                frm_en_q <= wdat[dwm_pkg::FRM_EN_BIT];
            end
            if (wr_hit(idx, dwm_pkg::IDX_FRM_LEN, wr)) begin
                frm_len_q <= (wdat & lane_mask) | (frm_len_q & ~lane_mask);
            end
        end
    end

    // A length of zero can never be reached, so it fires nothing.
    always_comb begin
        frm_fire = frm_en_q && FRAME_START && (frm_len_q != FRM_ZERO)
                   && (frm_cnt_q + FRM_ONE == frm_len_q);
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            frm_cnt_q <= FRM_ZERO;
        end else if (!frm_en_q || frm_fire) begin
            frm_cnt_q <= FRM_ZERO;
        end else if (FRAME_START) begin
            frm_cnt_q <= frm_cnt_q + FRM_ONE;
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            BLOCK_IRQ <= 1'b0;
        end else begin
            BLOCK_IRQ <= frm_fire;
        end
    end

    // Fault code: write one to clear; a new expiry wins over the clear.
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            fault_q <= dwm_pkg::REG_RESET;
        end else begin
            if (wr_hit(idx, dwm_pkg::IDX_FAULT_CODE, wr)) begin
                fault_q <= fault_q & ~(wdat & lane_mask);
            end
            if (wdg_expire) begin
                fault_q[dwm_pkg::FAULT_WDG_BIT] <= 1'b1;
            end
        end
    end

    assign WDG_ERROR = fault_q[dwm_pkg::FAULT_WDG_BIT];

    // Interrupt status, write one to clear, set wins over clear.
    always_comb begin
        irq_events = IRQ_ZERO;
        irq_events[dwm_pkg::IRQ_BLK_BIT] = frm_fire;
        irq_events[dwm_pkg::IRQ_WDG_BIT] = wdg_expire;
        irq_events[dwm_pkg::IRQ_ERR_BIT] = err_capture;
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            irq_stat_q <= IRQ_ZERO;
        end else if (wr_hit(idx, dwm_pkg::IDX_IRQ_STAT, wr) && WB_SEL_I[0]) begin
            irq_stat_q <= (irq_stat_q & ~wdat[dwm_pkg::IRQ_W-1:0])
                          | irq_events;
        end else begin
            irq_stat_q <= irq_stat_q | irq_events;
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            irq_mask_q <= IRQ_ZERO;
        end else if (wr_hit(idx, dwm_pkg::IDX_IRQ_MASK, wr) && WB_SEL_I[0]) begin
            irq_mask_q <= wdat[dwm_pkg::IRQ_W-1:0];
        end
    end

    // The interrupt line lags the status bits by one clock.
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(irq_stat_q & irq_mask_q);
        end
    end

    // Read mux; unmapped indices read as zero and are still acknowledged.
    always_comb begin
        rdata_d = 16'h0000;
        unique case (idx)
            dwm_pkg::IDX_ERR_PC:     rdata_d = err_pc_q;
            dwm_pkg::IDX_SW_CODE_A:  rdata_d = sw_code_a_q;
            dwm_pkg::IDX_SW_CODE_B:  rdata_d = sw_code_b_q;
            dwm_pkg::IDX_WDG_RELOAD: rdata_d[dwm_pkg::RELOAD_W-1:0] = reload_q;
            dwm_pkg::IDX_WDG_TICK:
                rdata_d[dwm_pkg::TICK_SEL_W-1:0] = tick_sel_q;
            dwm_pkg::IDX_FRM_EN:     rdata_d[dwm_pkg::FRM_EN_BIT] = frm_en_q;
            dwm_pkg::IDX_FRM_LEN:    rdata_d = frm_len_q;
            dwm_pkg::IDX_PC_UPPER:
                rdata_d[dwm_pkg::PC_UPPER_W-1:0] =
                    CORE_PC[dwm_pkg::PC_W-1:dwm_pkg::PC_UPPER_LSB];
            dwm_pkg::IDX_PC_LOWER:
                rdata_d = CORE_PC[15:0];
            dwm_pkg::IDX_FAULT_CODE: rdata_d = fault_q;
            dwm_pkg::IDX_IRQ_STAT:   rdata_d[dwm_pkg::IRQ_W-1:0] = irq_stat_q;
            dwm_pkg::IDX_IRQ_MASK:   rdata_d[dwm_pkg::IRQ_W-1:0] = irq_mask_q;
            default:                 rdata_d = 16'h0000;
        endcase
    end

    // Read data is registered with the ack and held until the next read request.
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            WB_DAT_O <= 32'h0000_0000;
        end else if (req && !WB_WE_I) begin
            WB_DAT_O <= {16'h0000, rdata_d};
        end
    end

endmodule

`default_nettype wire

// File: dv/dwm_watchdog_exec_monitor_assertions.sv
// Checker for bus answers, read-back fields and event outputs.
`default_nettype none

module dwm_chk (
    // Clock and reset.
    input wire logic        REF_CLK,
    input wire logic        NRST,
    // Bus.
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [17:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        WB_ACK_O,
    // Core and events.
    input wire logic [23:0] CORE_PC,
    input wire logic        FRAME_START,
    input wire logic        WDG_ERROR,
    input wire logic        BLOCK_IRQ
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!NRST);

    logic clr_wr;
    assign clr_wr = WB_CYC_I && WB_STB_I && !WB_ACK_O && WB_WE_I
                    && WB_ADR_I[17:2] == 16'hF470;

    sequence s_take;
        WB_CYC_I && WB_STB_I && !WB_ACK_O;
    endsequence

    sequence s_read(logic [15:0] idx);
        s_take ##0 (!WB_WE_I && WB_ADR_I[17:2] == idx);
    endsequence

    chk_ack_follow: assert property (s_take |=> WB_ACK_O)
        else $error("ack missing after request");
    chk_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    chk_pc_upper: assert property (s_read(16'hF460) |=>
        WB_DAT_O == {24'h000000, $past(CORE_PC[23:16])})
        else $error("upper count read wrong");
    chk_pc_lower: assert property (s_read(16'hF461) |=>
        WB_DAT_O == {16'h0000, $past(CORE_PC[15:0])})
        else $error("lower count read wrong");
    chk_reload_rsvd: assert property (s_read(16'hF443) |=>
        WB_DAT_O[31:13] == 19'h00000)
        else $error("reload reserved bits set");
    chk_tick_width: assert property (s_read(16'hF444) |=>
        WB_DAT_O[31:4] == 28'h0000000)
        else $error("tick select wider than four bits");
    chk_enable_bit: assert property (s_read(16'hF450) |=>
        WB_DAT_O[31:1] == 31'h00000000)
        else $error("enable reads more than one bit");
    chk_blk_cause: assert property (BLOCK_IRQ |-> $past(FRAME_START))
        else $error("block interrupt without frame pulse");
    chk_wdg_sticky: assert property ($fell(WDG_ERROR) |-> $past(clr_wr))
        else $error("watchdog flag dropped without clear");
endmodule

bind dwm_watchdog_exec_monitor dwm_chk dwm_chk_inst (
    .REF_CLK(REF_CLK), .NRST(NRST), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .CORE_PC(CORE_PC),
    .FRAME_START(FRAME_START), .WDG_ERROR(WDG_ERROR),
    .BLOCK_IRQ(BLOCK_IRQ)
);

`default_nettype wire

// File: dv/tb.sv
// Self-checking bench for the watchdog and execution monitor.
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic               REF_CLK, NRST, WB_CYC_I, WB_STB_I, WB_WE_I;
    logic [17:0]        WB_ADR_I;
    logic [3:0]         WB_SEL_I;
    logic [31:0]        WB_DAT_I, WB_DAT_O;
    logic               WB_ACK_O, CORE_ERROR, PROG_RESTART, FRAME_START;
    logic [23:0]        CORE_PC;
    logic [15:0]        EXEC_PC, rd;
    dwm_pkg::dwm_trap_t SW_TRAP;
    logic               WDG_ERROR, BLOCK_IRQ, IRQ;
    int                 n_errors, checks, cycles, n_blk;

    // Small prescaler base keeps every tick code affordable in the run.
    dwm_watchdog_exec_monitor #(.TICK_BASE_LOG2(1))
        dwm_watchdog_exec_monitor_inst (
        .REF_CLK(REF_CLK), .NRST(NRST), .WB_CYC_I(WB_CYC_I),
        .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
        .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
        .WB_ACK_O(WB_ACK_O), .CORE_PC(CORE_PC), .EXEC_PC(EXEC_PC),
        .CORE_ERROR(CORE_ERROR), .PROG_RESTART(PROG_RESTART),
        .FRAME_START(FRAME_START), .SW_TRAP(SW_TRAP),
        .WDG_ERROR(WDG_ERROR), .BLOCK_IRQ(BLOCK_IRQ), .IRQ(IRQ)
    );

    initial begin
        REF_CLK = 1'b0;
        forever #5 REF_CLK = ~REF_CLK;
    end

    task automatic complete_run();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge REF_CLK) begin
        cycles <= cycles + 1;
        if (BLOCK_IRQ === 1'b1) begin
            n_blk <= n_blk + 1;
        end
        if (cycles == 60000) begin
            n_errors++;
            complete_run();
        end
    end

    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One classic cycle; read data is taken at the ack edge only.
    task automatic wb(logic we, logic [15:0] idx, logic [15:0] d);
        @(posedge REF_CLK);
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        WB_WE_I  <= we;
        WB_ADR_I <= {idx, 2'b00};
        WB_DAT_I <= {16'h0000, d};
        do @(posedge REF_CLK); while (WB_ACK_O !== 1'b1);
        rd = WB_DAT_O[15:0];
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
        WB_WE_I  <= 1'b0;
    endtask

    // Counts cycles to expiry; slack covers the load and flag latency.
    task automatic wdg_time(int p);
        int n;
        n = 0;
        while (WDG_ERROR !== 1'b1 && n < 20000) begin
            @(posedge REF_CLK);
            n++;
        end
        check("expiry window", 16'(n >= 3*p-2 && n <= 3*p+3), 16'h0001);
        wb(1'b0, 16'hF470, 16'h0000);
        check("fault code", rd, 16'h1000);
        wb(1'b1, 16'hF470, 16'h1000);
        check("flag cleared", {15'h0000, WDG_ERROR}, 16'h0000);
    endtask

    task automatic s_regs();
        logic [15:0] idx [9] = '{16'hF432, 16'hF433, 16'hF434, 16'hF443,
            16'hF444, 16'hF450, 16'hF451, 16'hF460, 16'hF400};
        logic [15:0] msk [9] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h1FFF,
            16'h000F, 16'h0001, 16'hFFFF, 16'h0000, 16'h0000};
        for (int i = 0; i < 9; i++) begin
            wb(1'b0, idx[i], 16'h0000);
            check("reset value", rd, 16'h0000);
            wb(1'b1, idx[i], 16'hFFFF);
            wb(1'b0, idx[i], 16'h0000);
            check("read back", rd, msk[i]);
        end
    endtask

    task automatic s_core();
        @(posedge REF_CLK);
        CORE_PC <= 24'hA5C3E1;
        EXEC_PC <= 16'hBEEF;
        CORE_ERROR <= 1'b1;
        SW_TRAP <= '{store: 1'b1, sel_b: 1'b0, code: 16'h1234};
        @(posedge REF_CLK);
        CORE_ERROR <= 1'b0;
        SW_TRAP <= '{store: 1'b1, sel_b: 1'b1, code: 16'h5678};
        @(posedge REF_CLK);
        SW_TRAP <= '0;
        wb(1'b0, 16'hF460, 16'h0000);
        check("pc upper", rd, 16'h00A5);
        wb(1'b0, 16'hF461, 16'h0000);
        check("pc lower", rd, 16'hC3E1);
        wb(1'b0, 16'hF432, 16'h0000);
        check("error pc", rd, 16'hBEEF);
        wb(1'b0, 16'hF433, 16'h0000);
        check("trap code a", rd, 16'h1234);
        wb(1'b0, 16'hF434, 16'h0000);
        check("trap code b", rd, 16'h5678);
    endtask

    // Every defined tick code and reserved code 12, then a restart.
    task automatic s_wdg();
        for (int c = 0; c <= 12; c++) begin
            wb(1'b1, 16'hF444, 16'(c));
            wb(1'b1, 16'hF443, 16'h0003);
            wdg_time(2 << ((c > 11) ? 11 : c));
        end
        wb(1'b1, 16'hF444, 16'h0000);
        wb(1'b1, 16'hF443, 16'h0003);
        repeat (4) @(posedge REF_CLK);
        PROG_RESTART <= 1'b1;
        @(posedge REF_CLK);
        PROG_RESTART <= 1'b0;
        wdg_time(2);
    endtask

    task automatic s_irq();
        wb(1'b1, 16'hF472, 16'h0002);
        @(posedge REF_CLK);
        check("irq raised", {15'h0000, IRQ}, 16'h0001);
        wb(1'b1, 16'hF472, 16'h0000);
        @(posedge REF_CLK);
        check("irq masked", {15'h0000, IRQ}, 16'h0000);
        wb(1'b1, 16'hF471, 16'h0002);
        wb(1'b1, 16'hF472, 16'h0002);
        @(posedge REF_CLK);
        check("irq cleared", {15'h0000, IRQ}, 16'h0000);
    endtask

    task automatic s_frame();
        int base;
        wb(1'b1, 16'hF451, 16'h0003);
        for (int en = 0; en < 2; en++) begin
            wb(1'b1, 16'hF450, 16'(en));
            base = n_blk;
            for (int f = 1; f <= 7; f++) begin
                @(posedge REF_CLK);
                FRAME_START <= 1'b1;
                @(posedge REF_CLK);
                FRAME_START <= 1'b0;
                repeat (2) @(posedge REF_CLK);
                check("blocks", 16'(n_blk - base), 16'(en * (f / 3)));
            end
        end
        wb(1'b0, 16'hF471, 16'h0000);
        check("block status", rd & 16'h0001, 16'h0001);
    endtask

    initial begin
        NRST = 1'b0;
        {WB_CYC_I, WB_STB_I, WB_WE_I, CORE_ERROR} = 4'h0;
        {PROG_RESTART, FRAME_START} = 2'h0;
        WB_ADR_I = 18'h00000;
        WB_SEL_I = 4'hF;
        WB_DAT_I = 32'h00000000;
        CORE_PC = 24'h000000;
        EXEC_PC = 16'h0000;
        SW_TRAP = '0;
        {n_errors, checks, cycles, n_blk} = '0;
        repeat (10) @(posedge REF_CLK);
        NRST <= 1'b1;
        s_regs();
        s_core();
        s_wdg();
        s_irq();
        s_frame();
        complete_run();
    end
endmodule

`default_nettype wire
